// file: rtl/spd_top.sv
/*
  simd integer permute/move datapath slice: shuffles, quadword unpacks,
  64/128-bit moves, packed conversions, add/sub, compare and shifts.
  assumes decode presents one request per clock; result follows one clock
  later. the register files and load unit live outside.
*/
// Functional notes
// - 64-bit shuffle: result word i from source word at selector bits [2i+1:2i].
// - a 2-bit selector value is a source word index, 10 picks bits 47:32.
// - 64-bit shuffle source is a register or a memory operand, same selection.
// - low/high word shuffles permute one 64-bit half, copy the other.
// - doubleword shuffle places any source dword into any result dword.
// - quadword unpacks join low/high halves of dst and src, ignore others.
// - narrow to wide move writes low half and zeroes the upper 64 bits.
// - wide to narrow move keeps only the source's low 64 bits.
// - convert four singles to/from dwords; doubles to/from dwords.
// - no operation loads an immediate constant into a register.
// - equality compare of a value with itself gives all ones.
// - logical shifts exist for words and dwords only, not bytes.
// - saturating add/sub only for bytes and words, not dwords.
// - no signed-in, unsigned-saturate subtract exists.
// - plain word subtract wraps modulo 2^16; 0 - 8000h is 8000h.
`timescale 1ns/1ps
`default_nettype none
module spd_top (
  input  wire logic              clk_i,     // core clock
  input  wire logic              resetn_i,  // sync reset, active low
  input  wire spd_pkg::spd_req_t req_i,     // request from decode
  output var  spd_pkg::spd_rsp_t rsp_o      // registered result
);
  import spd_pkg::*;

  // 16-bit add/sub; bytes reuse it by riding in the upper byte
  function automatic logic [15:0] as_w(input logic [15:0] a, input logic [15:0] b,
                                       input logic sub, input spd_sat_t sat);
    logic [16:0] ux;
    logic [16:0] sx;
    logic [15:0] r;
    ux = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
    sx = sub ? ({a[15], a} - {b[15], b}) : ({a[15], a} + {b[15], b});
    r  = ux[15:0];
    if (sat == SPD_SAT_UNS && ux[16])
      r = sub ? 16'h0000 : 16'hFFFF;
    if (sat == SPD_SAT_SGN && (sx[16] != sx[15]))
      r = sx[16] ? SPD_W_MIN : 16'h7FFF;
    return r;
  endfunction

  // signed int32 to float, truncating the mantissa
  function automatic logic [63:0] i2f(input logic [31:0] v, input logic dbl);
    logic        sg;
    logic [31:0] a;
    logic [31:0] n;
    logic [4:0]  lz;
    logic [10:0] ex;
    logic [63:0] r;
    sg = v[31];
    a  = sg ? 32'(-v) : v;
    lz = 5'h00;
    for (int k = 0; k < 32; k++)
      if (a[k])
        lz = 5'(31 - k);
    n = a << lz;
    if (dbl)
    begin
      ex = 11'(SPD_DP_BIAS + 31) - 11'(lz);
      r  = {sg, ex, n[30:0], 21'h000000};
    end
    else
    begin
      ex = 11'(SPD_SP_BIAS + 31) - 11'(lz);
      r  = {32'h0000_0000, sg, ex[7:0], n[30:8]};
    end
    if (a == 32'h0000_0000)
      r = 64'h0;
    return r;
  endfunction

  logic [127:0] src;
  logic [127:0] dst;
  logic [7:0]   imm;
  logic [63:0]  sh_lo;
  logic [63:0]  sh_hi;
  logic [127:0] sh_d;
  logic [127:0] ps2dq;
  logic [127:0] dq2ps;
  logic [63:0]  pd2dq;
  logic [127:0] dq2pd;
  logic [127:0] as_res;
  logic [127:0] eq_res;
  logic [127:0] sl_res;
  logic [127:0] sr_res;
  logic [15:0]  eqb;
  logic         ill_arith;
  logic         ill_shift;
  logic         ill_size;
  logic [127:0] res_nxt;
  logic         ill_nxt;
  spd_rsp_t     rsp_r;

  assign src = req_i.use_mem ? req_i.src_mem : req_i.src_reg;
  assign dst = req_i.dst;
  assign imm = req_i.select_immediate;

  spd_wsel #(.W(SPD_WORD)) u_sel_lo (
    .src_i (src[63:0]),
    .sel_i (imm),
    .dst_o (sh_lo)
  );
  spd_wsel #(.W(SPD_WORD)) u_sel_hi (
    .src_i (src[127:64]),
    .sel_i (imm),
    .dst_o (sh_hi)
  );
  spd_wsel #(.W(SPD_DWORD)) u_sel_d (
    .src_i (src),
    .sel_i (imm),
    .dst_o (sh_d)
  );

  for (genvar i = 0; i < 4; i++)
  begin : g_sp
    logic [63:0] sp_w;
    spd_f2i #(.EW(SPD_SP_EW), .MW(SPD_SP_MW), .BIAS(SPD_SP_BIAS)) u_f2i (
      .fp_i  (src[32*i +: 32]),
      .int_o (ps2dq[32*i +: 32])
    );
    // single result sits in the low half of the shared converter output
    assign sp_w              = i2f(src[32*i +: 32], 1'b0);
    assign dq2ps[32*i +: 32] = sp_w[31:0];
  end
  for (genvar i = 0; i < 2; i++)
  begin : g_dp
    spd_f2i #(.EW(SPD_DP_EW), .MW(SPD_DP_MW), .BIAS(SPD_DP_BIAS)) u_f2i (
      .fp_i  (src[64*i +: 64]),
      .int_o (pd2dq[32*i +: 32])
    );
    assign dq2pd[64*i +: 64] = i2f(src[32*i +: 32], 1'b1);
  end

  always_comb
  begin
    logic [15:0] t;
    as_res = '0;
    eq_res = '0;
    sl_res = '0;
    sr_res = '0;
    t      = '0;
    for (int b = 0; b < 16; b++)
      eqb[b] = (dst[8*b +: 8] == src[8*b +: 8]);
    unique case (req_i.size)
      SPD_SZ_B:
      begin
        for (int b = 0; b < 16; b++)
        begin
          t = as_w({dst[8*b +: 8], 8'h00}, {src[8*b +: 8], 8'h00},
                   req_i.sub, req_i.sat);
          as_res[8*b +: 8] = t[15:8];
          eq_res[8*b +: 8] = {8{eqb[b]}};
        end
      end
      SPD_SZ_W:
      begin
        for (int w = 0; w < 8; w++)
        begin
          as_res[16*w +: 16] = as_w(dst[16*w +: 16], src[16*w +: 16],
                                    req_i.sub, req_i.sat);
          eq_res[16*w +: 16] = {16{&eqb[2*w +: 2]}};
          sl_res[16*w +: 16] = (imm >= 8'(SPD_WORD)) ? 16'h0000 : dst[16*w +: 16] << imm;
          sr_res[16*w +: 16] = (imm >= 8'(SPD_WORD)) ? 16'h0000 : dst[16*w +: 16] >> imm;
        end
      end
      SPD_SZ_D:
      begin
        for (int d = 0; d < 4; d++)
        begin
          as_res[32*d +: 32] = req_i.sub ? dst[32*d +: 32] - src[32*d +: 32]
                                         : dst[32*d +: 32] + src[32*d +: 32];
          eq_res[32*d +: 32] = {32{&eqb[4*d +: 4]}};
          sl_res[32*d +: 32] = (imm >= 8'(SPD_DWORD)) ? 32'h0 : dst[32*d +: 32] << imm;
          sr_res[32*d +: 32] = (imm >= 8'(SPD_DWORD)) ? 32'h0 : dst[32*d +: 32] >> imm;
        end
      end
      default:
      begin
        as_res = '0;
      end
    endcase
  end

  // no dword saturation and no mixed-sign saturation code
  assign ill_size  = !(req_i.size inside {SPD_SZ_B, SPD_SZ_W, SPD_SZ_D});
  assign ill_arith = ill_size || !(req_i.sat inside {SPD_SAT_NONE, SPD_SAT_SGN, SPD_SAT_UNS})
                     || (req_i.sat != SPD_SAT_NONE && req_i.size == SPD_SZ_D);
  assign ill_shift = !(req_i.size inside {SPD_SZ_W, SPD_SZ_D});

  always_comb
  begin
    res_nxt = '0;
    ill_nxt = 1'b0;
    unique case (req_i.op)
      SPD_OP_SHUF_W64: res_nxt = {64'h0, sh_lo};
      SPD_OP_SHUF_LW:  res_nxt = {src[127:64], sh_lo};
      SPD_OP_SHUF_HW:  res_nxt = {sh_hi, src[63:0]};
      SPD_OP_SHUF_D:   res_nxt = sh_d;
      SPD_OP_UNPK_LQ:  res_nxt = {src[63:0], dst[63:0]};
      SPD_OP_UNPK_HQ:  res_nxt = {src[127:64], dst[127:64]};
      SPD_OP_N2W_MOVE: res_nxt = {64'h0, src[63:0]};
      SPD_OP_W2N_MOVE: res_nxt = {64'h0, src[63:0]};
      SPD_OP_PS2DQ:    res_nxt = ps2dq;
      SPD_OP_DQ2PS:    res_nxt = dq2ps;
      SPD_OP_PD2DQ:    res_nxt = {64'h0, pd2dq};
      SPD_OP_DQ2PD:    res_nxt = dq2pd;
      SPD_OP_ADDSUB:   {ill_nxt, res_nxt} = {ill_arith, ill_arith ? 128'h0 : as_res};
      SPD_OP_CMPEQ:    {ill_nxt, res_nxt} = {ill_size, ill_size ? 128'h0 : eq_res};
      SPD_OP_SHL:      {ill_nxt, res_nxt} = {ill_shift, ill_shift ? 128'h0 : sl_res};
      SPD_OP_SHR:      {ill_nxt, res_nxt} = {ill_shift, ill_shift ? 128'h0 : sr_res};
      // any other code, an immediate load included, is refused
      default:         ill_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      rsp_r <= '0;
    else
    begin
      rsp_r.valid <= req_i.valid;
      if (req_i.valid)
      begin
        rsp_r.illegal <= ill_nxt;
        rsp_r.data    <= res_nxt;
      end
    end
  end

  assign rsp_o = rsp_r;

  // last-request copies read only by the checks below
  spd_req_t q_r;
  logic [127:0] q_src;
  always_ff @(posedge clk_i)
  begin
    q_r <= req_i;
  end
  assign q_src = q_r.use_mem ? q_r.src_mem : q_r.src_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_shuf_w64;
    rsp_o.valid && q_r.op == SPD_OP_SHUF_W64 |->
      rsp_o.data[15:0] == q_src[q_r.select_immediate[1:0]*16 +: 16] &&
      rsp_o.data[63:48] == q_src[q_r.select_immediate[7:6]*16 +: 16];
  endproperty
  a_shuf_w64: assert property (p_shuf_w64) else $error("word shuffle mismatch");

  property p_sel_two;
    req_i.valid && req_i.op == SPD_OP_SHUF_W64 && req_i.select_immediate[3:2] == 2'h2
      ##1 1'b1 |-> rsp_o.data[31:16] == q_src[47:32];
  endproperty
  a_sel_two: assert property (p_sel_two) else $error("selector 10 not word two");

  property p_mem_src;
    req_i.valid && req_i.op == SPD_OP_SHUF_W64 && req_i.use_mem |=>
      rsp_o.data[47:32] == q_r.src_mem[q_r.select_immediate[5:4]*16 +: 16];
  endproperty
  a_mem_src: assert property (p_mem_src) else $error("memory operand not used");

  property p_half_copy;
    rsp_o.valid && q_r.op == SPD_OP_SHUF_LW |-> rsp_o.data[127:64] == q_src[127:64];
  endproperty
  a_half_copy: assert property (p_half_copy) else $error("upper half not copied");

  property p_shuf_d;
    rsp_o.valid && q_r.op == SPD_OP_SHUF_D |->
      rsp_o.data[95:64] == q_src[q_r.select_immediate[5:4]*32 +: 32];
  endproperty
  a_shuf_d: assert property (p_shuf_d) else $error("dword shuffle mismatch");

  property p_hw_layout;
    rsp_o.valid && q_r.op == SPD_OP_SHUF_HW |->
      rsp_o.data[79:64] == q_src[64 + q_r.select_immediate[1:0]*16 +: 16] &&
      rsp_o.data[63:0] == q_src[63:0];
  endproperty
  a_hw_layout: assert property (p_hw_layout) else $error("high shuffle layout wrong");

  property p_unpk;
    rsp_o.valid && q_r.op == SPD_OP_UNPK_HQ |->
      rsp_o.data == {q_src[127:64], q_r.dst[127:64]};
  endproperty
  a_unpk: assert property (p_unpk) else $error("high unpack wrong");

  property p_n2w;
    rsp_o.valid && q_r.op == SPD_OP_N2W_MOVE |->
      rsp_o.data[127:64] == 64'h0 && rsp_o.data[63:0] == q_src[63:0];
  endproperty
  a_n2w: assert property (p_n2w) else $error("move halves wrong");

  property p_w2n;
    rsp_o.valid && q_r.op == SPD_OP_W2N_MOVE |->
      rsp_o.data[127:64] == 64'h0 && rsp_o.data[63:0] == q_src[63:0];
  endproperty
  a_w2n: assert property (p_w2n) else $error("narrow move kept upper");

  property p_cvt_one;
    req_i.valid && req_i.op == SPD_OP_DQ2PS && src[31:0] == 32'h1 |=>
      rsp_o.data[31:0] == SPD_SP_ONE && !rsp_o.illegal;
  endproperty
  a_cvt_one: assert property (p_cvt_one) else $error("int 1 not 1.0");

  property p_no_imm_load;
    req_i.valid && !(req_i.op inside {[SPD_OP_SHUF_W64:SPD_OP_SHR]}) |=> rsp_o.illegal;
  endproperty
  a_no_imm_load: assert property (p_no_imm_load) else $error("unknown op accepted");

  property p_self_eq;
    req_i.valid && req_i.op == SPD_OP_CMPEQ && req_i.dst == src && !ill_size |=>
      rsp_o.data == {128{1'b1}};
  endproperty
  a_self_eq: assert property (p_self_eq) else $error("self compare not all ones");

  property p_no_bshift;
    rsp_o.valid && q_r.op inside {SPD_OP_SHL, SPD_OP_SHR} |->
      rsp_o.illegal == (q_r.size == SPD_SZ_B || q_r.size == 2'h3);
  endproperty
  a_no_bshift: assert property (p_no_bshift) else $error("byte shift accepted");

  property p_no_dsat;
    rsp_o.valid && q_r.op == SPD_OP_ADDSUB && q_r.size == SPD_SZ_D &&
      q_r.sat != SPD_SAT_NONE |-> rsp_o.illegal && rsp_o.data == 128'h0;
  endproperty
  a_no_dsat: assert property (p_no_dsat) else $error("dword saturation accepted");

  property p_no_mixsat;
    req_i.valid && req_i.op == SPD_OP_ADDSUB && req_i.sat == 2'h3 |=> rsp_o.illegal;
  endproperty
  a_no_mixsat: assert property (p_no_mixsat) else $error("mixed saturation accepted");

  property p_wrap;
    rsp_o.valid && q_r.op == SPD_OP_ADDSUB && q_r.size == SPD_SZ_W && q_r.sub &&
      q_r.sat == SPD_SAT_NONE && q_r.dst[15:0] == 16'h0 && q_src[15:0] == SPD_W_MIN
      |-> rsp_o.data[15:0] == SPD_W_MIN;
  endproperty
  a_wrap: assert property (p_wrap) else $error("word subtract did not wrap");
endmodule
`default_nettype wire

// file: inc/spd_pkg.sv
/*
  shared types and constants for the simd permute/move datapath slice.
  assumes the decode stage drives one request struct per clock.
*/
`default_nettype none
package spd_pkg;
  localparam int unsigned SPD_DW     = 128;
  localparam int unsigned SPD_HW     = 64;
  localparam int unsigned SPD_WORD   = 16;
  localparam int unsigned SPD_DWORD  = 32;
  localparam int unsigned SPD_BYTE   = 8;
  localparam int unsigned SPD_SEL_W  = 2;
  localparam int unsigned SPD_SP_EW  = 8;
  localparam int unsigned SPD_SP_MW  = 23;
  localparam int unsigned SPD_SP_BIAS = 127;
  localparam int unsigned SPD_DP_EW  = 11;
  localparam int unsigned SPD_DP_MW  = 52;
  localparam int unsigned SPD_DP_BIAS = 1023;
  localparam logic [31:0] SPD_INT_INDEF = 32'h8000_0000;
  localparam logic [31:0] SPD_SP_ONE    = 32'h3F80_0000;
  localparam logic [15:0] SPD_W_MIN     = 16'h8000;

  typedef enum logic [4:0] {
    SPD_OP_SHUF_W64 = 5'h00,
    SPD_OP_SHUF_LW  = 5'h01,
    SPD_OP_SHUF_HW  = 5'h02,
    SPD_OP_SHUF_D   = 5'h03,
    SPD_OP_UNPK_LQ  = 5'h04,
    SPD_OP_UNPK_HQ  = 5'h05,
    SPD_OP_N2W_MOVE = 5'h06,
    SPD_OP_W2N_MOVE = 5'h07,
    SPD_OP_PS2DQ    = 5'h08,
    SPD_OP_DQ2PS    = 5'h09,
    SPD_OP_PD2DQ    = 5'h0A,
    SPD_OP_DQ2PD    = 5'h0B,
    SPD_OP_ADDSUB   = 5'h0C,
    SPD_OP_CMPEQ    = 5'h0D,
    SPD_OP_SHL      = 5'h0E,
    SPD_OP_SHR      = 5'h0F
  } spd_op_t;

  typedef enum logic [1:0] {
    SPD_SZ_B = 2'h0,
    SPD_SZ_W = 2'h1,
    SPD_SZ_D = 2'h2
  } spd_size_t;

  typedef enum logic [1:0] {
    SPD_SAT_NONE = 2'h0,
    SPD_SAT_SGN  = 2'h1,
    SPD_SAT_UNS  = 2'h2
  } spd_sat_t;

  typedef struct packed {
    logic          valid;
    spd_op_t       op;
    spd_size_t     size;
    spd_sat_t      sat;
    logic          sub;
    logic          use_mem;
    logic [7:0]    select_immediate;
    logic [127:0]  dst;
    logic [127:0]  src_reg;
    logic [127:0]  src_mem;
  } spd_req_t;

  typedef struct packed {
    logic          valid;
    logic          illegal;
    logic [127:0]  data;
  } spd_rsp_t;
endpackage
`default_nettype wire

// file: rtl/spd_wsel.sv
/*
  four-element selector: result element i takes the source element named
  by selector bits [2i+1:2i]. purely combinational, no clock.
*/
`timescale 1ns/1ps
`default_nettype none
module spd_wsel #(
  parameter int unsigned W = 16
) (
  input  wire logic [4*W-1:0] src_i,  // four source elements
  input  wire logic [7:0]     sel_i,  // 2-bit field per result element
  output logic      [4*W-1:0] dst_o   // permuted elements
);
  for (genvar i = 0; i < 4; i++)
  begin : g_el
    assign dst_o[i*W +: W] = src_i[sel_i[2*i +: 2]*W +: W];
  end
endmodule
`default_nettype wire

// file: rtl/spd_f2i.sv
/*
  float to 32-bit signed integer, truncating toward zero.
  out of range, infinity and nan give the integer indefinite value.
*/
`timescale 1ns/1ps
`default_nettype none
module spd_f2i #(
  parameter int unsigned EW   = 8,
  parameter int unsigned MW   = 23,
  parameter int unsigned BIAS = 127
) (
  input  wire logic [EW+MW:0] fp_i,   // ieee float
  output logic      [31:0]    int_o   // signed result
);
  import spd_pkg::*;
  localparam logic signed [13:0] MW_S   = 14'(MW);
  localparam logic signed [13:0] BIAS_S = 14'(BIAS);
  localparam logic signed [13:0] TOP_S  = 14'(SPD_DWORD - 1);

  logic              sgn;
  logic [EW-1:0]     ex;
  logic signed [13:0] e;
  logic [63:0]       ext;
  logic [63:0]       mag;
  logic              oor;

  assign sgn = fp_i[EW+MW];
  assign ex  = fp_i[MW +: EW];
  assign e   = signed'(14'(ex)) - BIAS_S;
  assign ext = 64'({1'b1, fp_i[MW-1:0]});
  assign mag = (e >= MW_S) ? (ext << 6'(e - MW_S)) : (ext >> 6'(MW_S - e));
  // -2^31 also lands here and yields the same pattern, so it stays exact
  assign oor = (&ex) | (e >= TOP_S);
  assign int_o = oor ? SPD_INT_INDEF :
                 (e < 14'sd0) ? 32'h0000_0000 :
                 sgn ? 32'(-mag[31:0]) : mag[31:0];
endmodule
`default_nettype wire

// file: bench/spd_decode_model.sv
/*
  far-side model: decode stage, register files and load unit feeding req_i.
  assumes the bench calls issue() or idle() just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module spd_decode_model (
  input  wire logic              clk_i,  // core clock
  output var  spd_pkg::spd_req_t req_o   // request towards the slice
);
  import spd_pkg::*;

  initial req_o = '0;

  task automatic issue(input spd_req_t r);
    req_o = r;
  endtask

  task automatic idle();
    req_o.valid = 1'b0;
  endtask

  // idle operands churn every cycle so stale values are never mistaken for live ones
  always @(negedge clk_i)
  begin
    if (!req_o.valid)
    begin
      req_o.dst              = ~req_o.dst;
      req_o.src_reg          = ~req_o.src_reg;
      req_o.src_mem          = ~req_o.src_mem;
      req_o.select_immediate = ~req_o.select_immediate;
    end
  end
endmodule
`default_nettype wire

// file: bench/spd_top_tb_top.sv
/*
  self-checking bench for the permute/move slice: random shuffles, unpacks
  and moves plus fixed corner cases. assumes a one-cycle registered answer.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_mismatch++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module spd_top_tb_top;
  import spd_pkg::*;

  logic      clk_i;
  logic      resetn_i;
  spd_req_t  req;
  spd_rsp_t  rsp;
  int        n_mismatch;
  int        checks;
  int        cyc;

  spd_decode_model PARTNER (
    .clk_i (clk_i),
    .req_o (req)
  );

  spd_top DUT (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .req_i    (req),
    .rsp_o    (rsp)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // a hung run still reaches the verdict
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  function automatic logic [63:0] sw(input logic [63:0] s, input logic [7:0] im);
    logic [63:0] r;
    for (int i = 0; i < 4; i++) r[16*i +: 16] = s[16*im[2*i +: 2] +: 16];
    return r;
  endfunction

  function automatic logic [127:0] sd(input logic [127:0] s, input logic [7:0] im);
    logic [127:0] r;
    for (int i = 0; i < 4; i++) r[32*i +: 32] = s[32*im[2*i +: 2] +: 32];
    return r;
  endfunction

  function automatic logic [127:0] shw(input logic [127:0] d, input int n);
    logic [127:0] r;
    for (int i = 0; i < 8; i++) r[16*i +: 16] = (n >= 16) ? 16'h0000 : d[16*i +: 16] << n;
    return r;
  endfunction

  function automatic logic [127:0] rnd();
    return {$urandom, $urandom, $urandom, $urandom};
  endfunction

  // the operand not selected by use_mem carries the inverse, so a wrong pick shows
  function automatic spd_req_t mk(input spd_op_t op, input logic [1:0] sz,
                                  input logic [1:0] st, input logic sb,
                                  input logic [7:0] im, input logic [127:0] d,
                                  input logic [127:0] s, input logic um);
    spd_req_t r;
    r.valid            = 1'b1;
    r.op               = op;
    r.size             = spd_size_t'(sz);
    r.sat              = spd_sat_t'(st);
    r.sub              = sb;
    r.use_mem          = um;
    r.select_immediate = im;
    r.dst              = d;
    r.src_reg          = um ? ~s : s;
    r.src_mem          = um ? s : ~s;
    return r;
  endfunction

  // caller stands just after an edge; the answer is looked at one edge later
  task automatic xfer(input spd_req_t r, input logic il, input logic [127:0] ex);
    PARTNER.issue(r);
    @(posedge clk_i);
    #1;
    `CHK("rsp.valid", 1'b1, rsp.valid)
    `CHK("rsp.illegal", il, rsp.illegal)
    `CHK("rsp.data", ex, rsp.data)
  endtask

  initial
  begin
    logic [127:0] s;
    logic [127:0] d;
    logic [7:0]   im;
    logic         um;
    int           n;
    n_mismatch = 0;
    checks     = 0;
    cyc        = 0;
    resetn_i   = 1'b0;
    void'($urandom(32'h555303F0));
    repeat (10) @(posedge clk_i);
    #1;
    `CHK("reset rsp", '0, rsp)
    resetn_i = 1'b1;
    s = 128'h0000_0000_0000_0000_0004_0003_0002_0001;
    xfer(mk(SPD_OP_SHUF_W64, 2'h0, 2'h0, 1'b0, 8'h1B, rnd(), s, 1'b0), 1'b0,
         128'h0001_0002_0003_0004);
    xfer(mk(SPD_OP_SHUF_W64, 2'h0, 2'h0, 1'b0, 8'hAA, rnd(), s, 1'b1), 1'b0,
         128'h0003_0003_0003_0003);
    for (int k = 0; k < 8; k++)
    begin
      s  = rnd();
      d  = rnd();
      im = 8'($urandom);
      um = 1'($urandom);
      xfer(mk(SPD_OP_SHUF_W64, 2'h0, 2'h0, 1'b0, im, d, s, um), 1'b0, {64'h0, sw(s[63:0], im)});
      xfer(mk(SPD_OP_SHUF_LW, 2'h0, 2'h0, 1'b0, im, d, s, um), 1'b0,
           {s[127:64], sw(s[63:0], im)});
      xfer(mk(SPD_OP_SHUF_HW, 2'h0, 2'h0, 1'b0, im, d, s, um), 1'b0,
           {sw(s[127:64], im), s[63:0]});
      xfer(mk(SPD_OP_SHUF_D, 2'h0, 2'h0, 1'b0, im, d, s, um), 1'b0, sd(s, im));
      xfer(mk(SPD_OP_UNPK_LQ, 2'h0, 2'h0, 1'b0, im, d, s, um), 1'b0, {s[63:0], d[63:0]});
      xfer(mk(SPD_OP_UNPK_HQ, 2'h0, 2'h0, 1'b0, im, d, s, um), 1'b0, {s[127:64], d[127:64]});
      xfer(mk(SPD_OP_N2W_MOVE, 2'h0, 2'h0, 1'b0, im, d, s, um), 1'b0, {64'h0, s[63:0]});
      xfer(mk(SPD_OP_W2N_MOVE, 2'h0, 2'h0, 1'b0, im, d, s, um), 1'b0, {64'h0, s[63:0]});
      n = int'($urandom_range(18));
      xfer(mk(SPD_OP_SHL, 2'h1, 2'h0, 1'b0, 8'(n), d, s, um), 1'b0, shw(d, n));
    end
    // conversions: infinity, negative, one, truncated fraction
    s = {32'h7F80_0000, 32'hC000_0000, 32'h3F80_0000, 32'h4049_0FDB};
    xfer(mk(SPD_OP_PS2DQ, 2'h0, 2'h0, 1'b0, 8'h00, rnd(), s, 1'b0), 1'b0,
         {32'h8000_0000, 32'hFFFF_FFFE, 32'h0000_0001, 32'h0000_0003});
    s = {32'hFFFF_FFFE, 32'h0000_0003, 32'h0000_0000, 32'h0000_0001};
    xfer(mk(SPD_OP_DQ2PS, 2'h0, 2'h0, 1'b0, 8'h00, rnd(), s, 1'b1), 1'b0,
         {32'hC000_0000, 32'h4040_0000, 32'h0000_0000, 32'h3F80_0000});
    s = {64'h1234_5678_9ABC_DEF0, 32'hFFFF_FFFE, 32'h0000_0001};
    xfer(mk(SPD_OP_DQ2PD, 2'h0, 2'h0, 1'b0, 8'h00, rnd(), s, 1'b0), 1'b0,
         {64'hC000_0000_0000_0000, 64'h3FF0_0000_0000_0000});
    s = {64'hC000_0000_0000_0000, 64'h3FF0_0000_0000_0000};
    xfer(mk(SPD_OP_PD2DQ, 2'h0, 2'h0, 1'b0, 8'h00, rnd(), s, 1'b0), 1'b0,
         {96'h0, 32'h0000_0001} | {64'h0, 32'hFFFF_FFFE, 32'h0});
    // refusals answer with illegal set and zero data; then unsigned saturation and word wrap, which are legal
    xfer(mk(spd_op_t'(5'h10), 2'h0, 2'h0, 1'b0, 8'hFF, rnd(), rnd(), 1'b0), 1'b1, '0);
    xfer(mk(SPD_OP_SHL, 2'h0, 2'h0, 1'b0, 8'h01, rnd(), rnd(), 1'b0), 1'b1, '0);
    xfer(mk(SPD_OP_SHR, 2'h0, 2'h0, 1'b0, 8'h01, rnd(), rnd(), 1'b0), 1'b1, '0);
    xfer(mk(SPD_OP_ADDSUB, 2'h2, 2'h1, 1'b1, 8'h00, rnd(), rnd(), 1'b0), 1'b1, '0);
    xfer(mk(SPD_OP_ADDSUB, 2'h2, 2'h2, 1'b0, 8'h00, rnd(), rnd(), 1'b0), 1'b1, '0);
    xfer(mk(SPD_OP_ADDSUB, 2'h1, 2'h3, 1'b1, 8'h00, rnd(), rnd(), 1'b0), 1'b1, '0);
    xfer(mk(SPD_OP_ADDSUB, 2'h1, 2'h2, 1'b1, 8'h00, {8{16'h0001}}, {8{16'h0002}}, 1'b0),
         1'b0, '0);
    xfer(mk(SPD_OP_ADDSUB, 2'h0, 2'h2, 1'b0, 8'h00, {16{8'hFF}}, {16{8'h01}}, 1'b1),
         1'b0, {16{8'hFF}});
    xfer(mk(SPD_OP_ADDSUB, 2'h1, 2'h0, 1'b1, 8'h00, '0, {8{SPD_W_MIN}}, 1'b0),
         1'b0, {8{16'h8000}});
    // signed saturation and plain dword wrap are legal and must not be refused
    xfer(mk(SPD_OP_ADDSUB, 2'h1, 2'h1, 1'b0, 8'h00, {8{16'h7FFF}}, {8{16'h0001}}, 1'b0),
         1'b0, {8{16'h7FFF}});
    xfer(mk(SPD_OP_ADDSUB, 2'h0, 2'h1, 1'b1, 8'h00, {16{8'h80}}, {16{8'h01}}, 1'b1),
         1'b0, {16{8'h80}});
    xfer(mk(SPD_OP_ADDSUB, 2'h2, 2'h0, 1'b0, 8'h00, {4{32'hFFFF_FFFF}}, {4{32'h1}}, 1'b0),
         1'b0, '0);
    xfer(mk(SPD_OP_SHR, 2'h2, 2'h0, 1'b0, 8'h04, {4{32'h8000_0001}}, rnd(), 1'b0), 1'b0,
         {4{32'h0800_0000}});
    for (int z = 0; z < 3; z++)
    begin
      d = rnd();
      xfer(mk(SPD_OP_CMPEQ, 2'(z), 2'h0, 1'b0, 8'h00, d, d, 1'b0), 1'b0, {128{1'b1}});
    end
    d = rnd();
    xfer(mk(SPD_OP_CMPEQ, 2'h0, 2'h0, 1'b0, 8'h00, d, d ^ 128'hFF00, 1'b1), 1'b0,
         ~128'hFF00);
    PARTNER.idle();
    @(posedge clk_i);
    #1;
    `CHK("idle valid", 1'b0, rsp.valid)
    `CHK("idle data", ~128'hFF00, rsp.data)
    test_done();
  end
endmodule
`default_nettype wire
